/* File: bench/ctp_cpu_model.sv */
`default_nettype none
module ctp_cpu_model (
  input wire logic mclk,
  input wire logic slow,
  input wire logic cpu_stop_request_n,
  output logic cpu_stop_ack_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0] req_q = 6'h3F;
  // Processor side: acknowledges a stop request, promptly or after six cycles
  always @(posedge mclk) begin
    req_q <= {req_q[4:0], cpu_stop_request_n};
  end
  // Ack is released together with the request, never held over
  assign cpu_stop_ack_n = (slow ? req_q[5] : req_q[0]) | cpu_stop_request_n;
endmodule // ctp_cpu_model
`default_nettype wire

/* File: bench/test_cpu_throttle_power_config.sv */
`default_nettype none
module test_cpu_throttle_power_config
  import ctp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic cfg_wr = 1'h0, cfg_rd = 1'h0, mem_rd = 1'h0, io_wr = 1'h0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, mem_addr = 8'h00, io_wdata = 8'h00;
  logic [7:0] off_count = 8'h00, on_count = 8'h00, cfg_rdata;
  logic [15:0] io_addr = 16'h0000, mem_rdata, rd;
  logic smi_event = 1'h0, irq_speedup_active = 1'h0, wake_event = 1'h0, slow = 1'h0;
  logic video_speedup_trigger = 1'h0, video_speedup_active = 1'h0;
  logic clock_stop_ctrl = 1'h0, smi_status_any = 1'h0;
  logic cpu_stop_ack_n, cpu_stop_request_n, system_mgmt_interrupt, irq_speedup_load;
  logic power_savings_en, isa_clk_stop_include, low_voltage_suspend_en;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int k;

  always #10 mclk = ~mclk;

  // Short window and interval keep the run brief
  ctp_throttle_cfg #(.VID_WIN_CYC_P(20), .IVL_CYC_P(4)) dut (
    .mclk(mclk), .srst(srst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .io_wr(io_wr), .io_addr(io_addr), .io_wdata(io_wdata),
    .off_count(off_count), .on_count(on_count), .smi_event(smi_event),
    .irq_speedup_active(irq_speedup_active), .video_speedup_trigger(video_speedup_trigger),
    .video_speedup_active(video_speedup_active), .clock_stop_ctrl(clock_stop_ctrl),
    .smi_status_any(smi_status_any), .wake_event(wake_event),
    .cpu_stop_ack_n(cpu_stop_ack_n), .cpu_stop_request_n(cpu_stop_request_n),
    .system_mgmt_interrupt(system_mgmt_interrupt), .irq_speedup_load(irq_speedup_load),
    .power_savings_en(power_savings_en), .isa_clk_stop_include(isa_clk_stop_include),
    .low_voltage_suspend_en(low_voltage_suspend_en)
  );

  ctp_cpu_model cpu (
    .mclk(mclk), .slow(slow), .cpu_stop_request_n(cpu_stop_request_n),
    .cpu_stop_ack_n(cpu_stop_ack_n)
  );

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // All drives land 1 ns after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // Idle edge first, so back-to-back calls never re-raise a strobe in one step
  task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    cfg_addr = a;
    cfg_wdata = d;
    cfg_wr = 1'h1;
    tick(1);
    cfg_wr = 1'h0;
  endtask

  task automatic cfg_read(input logic [7:0] a, output logic [15:0] d);
    tick(1);
    cfg_addr = a;
    cfg_rd = 1'h1;
    tick(1);
    cfg_rd = 1'h0;
    d = {8'h00, cfg_rdata};
  endtask

  task automatic io_write(input logic [15:0] a, input logic [7:0] d);
    tick(1);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'h1;
    tick(1);
    io_wr = 1'h0;
  endtask

  task automatic pulse_smi;
    smi_event = 1'h1;
    tick(1);
    smi_event = 1'h0;
  endtask

  task automatic count_low(input int n, output int c);
    c = 0;
    repeat (n) begin
      tick(1);
      if (cpu_stop_request_n === 1'h0) c++;
    end
  endtask

  task automatic wait_req(input logic v, input int lim);
    for (int i = 0; i < lim && cpu_stop_request_n !== v; i++) tick(1);
    chk({15'h0000, cpu_stop_request_n}, {15'h0000, v});
  endtask

  task automatic t_reset;
    cfg_read(CTP_IDX_THR_CFG, rd);
    chk(rd, 16'h0000);
    cfg_read(CTP_IDX_VOVF_LO, rd);
    chk(rd, 16'h0000);
    chk({11'h000, power_savings_en, isa_clk_stop_include, low_voltage_suspend_en,
         system_mgmt_interrupt, cpu_stop_request_n}, 16'h0011);
  endtask

  task automatic t_cfg_bits;
    logic [7:0] wv [3] = '{8'h1F, 8'h10, 8'h0C};
    logic [2:0] ev [3] = '{3'h3, 3'h0, 3'h7};
    for (int i = 0; i < 3; i++) begin
      cfg_write(CTP_IDX_THR_CFG, wv[i]);
      cfg_read(CTP_IDX_THR_CFG, rd);
      chk(rd, {8'h00, wv[i] & 8'h1F});
      chk({13'h0000, power_savings_en, isa_clk_stop_include, low_voltage_suspend_en},
          {13'h0000, ev[i]});
    end
    cfg_write(CTP_IDX_THR_CFG, 8'h00);
  endtask

  task automatic t_shadow;
    logic [15:0] pa [4] = '{16'h03F2, 16'h03F7, 16'h01F2, 16'h01F7};
    logic [7:0] pd [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hC3};
    for (int i = 0; i < 4; i++) io_write(pa[i], pd[i]);
    // Near-miss addresses and direct writes must leave the copies alone
    io_write(16'h13F2, 8'hFF);
    io_write(16'h03F3, 8'hFF);
    cfg_write(CTP_IDX_SH_3F2, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cfg_read(CTP_IDX_SH_3F2 + 8'(i), rd);
      chk(rd, {8'h00, pd[i]});
    end
    io_write(16'h03F2, 8'h66);
    cfg_read(CTP_IDX_SH_3F2, rd);
    chk(rd, 16'h0066);
  endtask

  task automatic t_sw_smi;
    cfg_write(CTP_IDX_THR_CFG, 8'h01);
    // Running speedup timer holds throttling off; zero counts toggle every interval
    irq_speedup_active = 1'h1;
    tick(3);
    count_low(20, k);
    chk(16'(k), 16'h0000);
    irq_speedup_active = 1'h0;
    count_low(40, k);
    chk(16'(k), 16'h0014);
    cfg_write(CTP_IDX_SW_SMI, 8'hAB);
    chk({14'h0000, system_mgmt_interrupt, irq_speedup_load}, 16'h0003);
    tick(1);
    chk({15'h0000, system_mgmt_interrupt}, 16'h0000);
    smi_event = 1'h1;
    #1;
    chk({15'h0000, irq_speedup_load}, 16'h0001);
    tick(1);
    smi_event = 1'h0;
    cfg_write(CTP_IDX_THR_CFG, 8'h00);
  endtask

  task automatic t_halt;
    // Two intervals off, three on: a 20-cycle period gives 24 low in 40
    off_count = 8'h02;
    on_count = 8'h03;
    cfg_write(CTP_IDX_THR_CFG, 8'h03);
    count_low(40, k);
    chk(16'(k), 16'h0018);
    pulse_smi();
    tick(3);
    count_low(40, k);
    chk(16'(k), 16'h0000);
    mem_addr = CTP_OFS_REARM;
    mem_rd = 1'h1;
    tick(1);
    mem_rd = 1'h0;
    chk(mem_rdata, 16'h0000);
    count_low(40, k);
    chk({15'h0000, k > 0}, 16'h0001);
    cfg_write(CTP_IDX_THR_CFG, 8'h00);
    tick(3);
    count_low(20, k);
    chk(16'(k), 16'h0000);
    // Policy set but feature off: an SYSTEM_MGMT_INTERRUPT must not latch a halt
    cfg_write(CTP_IDX_THR_CFG, 8'h02);
    pulse_smi();
    cfg_write(CTP_IDX_THR_CFG, 8'h03);
    count_low(40, k);
    chk({15'h0000, k > 0}, 16'h0001);
    cfg_write(CTP_IDX_THR_CFG, 8'h00);
    tick(4);
  endtask

  task automatic t_video;
    video_speedup_active = 1'h1;
    repeat (3) begin
      video_speedup_trigger = 1'h1;
      tick(1);
      video_speedup_trigger = 1'h0;
      tick(15);
    end
    video_speedup_active = 1'h0;
    cfg_read(CTP_IDX_VOVF_LO, rd);
    chk(rd, 16'h0000);
    video_speedup_active = 1'h1;
    video_speedup_trigger = 1'h1;
    tick(1);
    video_speedup_trigger = 1'h0;
    tick(50);
    video_speedup_active = 1'h0;
    tick(5);
    cfg_read(CTP_IDX_VOVF_LO, rd);
    chk(rd, 16'h0002);
    cfg_read(CTP_IDX_VOVF_HI, rd);
    chk(rd, 16'h0000);
    tick(20);
    cfg_read(CTP_IDX_VOVF_LO, rd);
    chk(rd, 16'h0002);
    cfg_write(CTP_IDX_VOVF_LO, 8'h00);
    cfg_read(CTP_IDX_VOVF_LO, rd);
    chk(rd, 16'h0000);
  endtask

  task automatic t_suspend;
    clock_stop_ctrl = 1'h1;
    cfg_write(CTP_IDX_CPU_STOP_REQUEST_N_CMD, 8'h00);
    count_low(10, k);
    chk(16'(k), 16'h0000);
    clock_stop_ctrl = 1'h0;
    smi_status_any = 1'h1;
    cfg_write(CTP_IDX_CPU_STOP_REQUEST_N_CMD, 8'h00);
    count_low(10, k);
    chk(16'(k), 16'h0000);
    smi_status_any = 1'h0;
    for (int s = 0; s < 2; s++) begin
      slow = s[0];
      cfg_write(CTP_IDX_CPU_STOP_REQUEST_N_CMD, 8'h55);
      wait_req(1'h0, 5);
      tick(20);
      chk({15'h0000, cpu_stop_request_n}, 16'h0000);
      wake_event = 1'h1;
      tick(1);
      wake_event = 1'h0;
      wait_req(1'h1, 6);
      tick(10);
    end
    slow = 1'h0;
  endtask

  initial begin
    tick(12);
    srst = 1'h0;
    t_reset();
    t_cfg_bits();
    t_shadow();
    t_sw_smi();
    t_halt();
    t_video();
    t_suspend();
    close_out();
  end
endmodule // test_cpu_throttle_power_config
`default_nettype wire

/* File: hw/ctp_ctl_if.sv */
`default_nettype none
interface ctp_ctl_if;
  logic thr_run;
  logic [7:0] off_count;
  logic [7:0] on_count;
  logic mod_stop;
  logic vid_trig;
  logic vid_active;
  logic ovf_inc;
  modport top_mp (output thr_run, off_count, on_count, vid_trig, vid_active,
                  input mod_stop, ovf_inc);
  modport mod_mp (input thr_run, off_count, on_count, output mod_stop);
  modport vid_mp (input vid_trig, vid_active, output ovf_inc);
endinterface
`default_nettype wire

/* File: hw/ctp_modulator.sv */
`default_nettype none
module ctp_modulator
  import ctp_pkg::*;
#(
  parameter int IVL_CYC_P = CTP_IVL_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  ctp_ctl_if.mod_mp ctl
);
  localparam int TW = $clog2(IVL_CYC_P);
  if (IVL_CYC_P < 2) begin : g_chk
    $error("ctp_modulator: interval must be at least two cycles");
  end
  logic [TW-1:0] tick_q;
  logic tick;
  logic phase_q;
  logic [7:0] ivl_q;
  logic [7:0] cur;

  assign tick = (tick_q == TW'(IVL_CYC_P - 1));
  assign cur = phase_q ? ctl.on_count : ctl.off_count;

  // Speedup or disable restarts the interval clock too
  always_ff @(posedge mclk) begin
    if (srst || !ctl.thr_run) begin
      tick_q <= '0;
    end else if (tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + TW'(1);
    end
  end

  // A zero count still lasts one interval
  always_ff @(posedge mclk) begin
    if (srst || !ctl.thr_run) begin
      phase_q <= 1'b0;
      ivl_q <= 8'h00;
    end else if (tick) begin
      if ((ivl_q + 8'h01) >= cur || cur == 8'h00) begin
        phase_q <= !phase_q;
        ivl_q <= 8'h00;
      end else begin
        ivl_q <= ivl_q + 8'h01;
      end
    end
  end

  assign ctl.mod_stop = phase_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_mod_idle;
    !ctl.thr_run |=> !ctl.mod_stop;
  endproperty
  a_mod_idle: assert property (p_mod_idle) else $error("stop request while throttle off");
  property p_mod_toggle;
    ctl.thr_run && tick && cur == 8'h00 |=> ctl.mod_stop != $past(ctl.mod_stop);
  endproperty
  a_mod_toggle: assert property (p_mod_toggle) else $error("phase did not switch");
endmodule // ctp_modulator
`default_nettype wire

/* File: hw/ctp_pkg.sv */
`default_nettype none
package ctp_pkg;
  // Function 0 configuration indices
  localparam logic [7:0] CTP_IDX_THR_CFG = 8'h96;
  localparam logic [7:0] CTP_IDX_VOVF_LO = 8'hA8;
  localparam logic [7:0] CTP_IDX_VOVF_HI = 8'hA9;
  localparam logic [7:0] CTP_IDX_CPU_STOP_REQUEST_N_CMD = 8'hAE;
  localparam logic [7:0] CTP_IDX_SH_3F2 = 8'hB4;
  localparam logic [7:0] CTP_IDX_SH_3F7 = 8'hB5;
  localparam logic [7:0] CTP_IDX_SH_1F2 = 8'hB6;
  localparam logic [7:0] CTP_IDX_SH_1F7 = 8'hB7;
  localparam logic [7:0] CTP_IDX_SW_SMI = 8'hD0;
  // Function 1 memory offset
  localparam logic [7:0] CTP_OFS_REARM = 8'h08;
  // Throttle configuration fields
  localparam int CTP_THR_EN_BIT = 0;
  localparam int CTP_SMI_POL_BIT = 1;
  localparam int CTP_LV_CPU_STOP_REQUEST_N_BIT = 2;
  localparam int CTP_ISA_CLK_BIT = 3;
  localparam int CTP_PWR_DIS_BIT = 4;
  localparam logic [7:0] CTP_THR_CFG_RST = 8'h00;
  localparam logic [7:0] CTP_THR_CFG_WMASK = 8'h1F;
  localparam logic [15:0] CTP_VOVF_RST = 16'h0000;
  localparam logic [15:0] CTP_REARM_RDATA = 16'h0000;
  // Snooped I/O ports
  localparam logic [15:0] CTP_PORT_3F2 = 16'h03F2;
  localparam logic [15:0] CTP_PORT_3F7 = 16'h03F7;
  localparam logic [15:0] CTP_PORT_1F2 = 16'h01F2;
  localparam logic [15:0] CTP_PORT_1F7 = 16'h01F7;
  // Timing
  localparam int CTP_CLK_MHZ = 50;
  localparam int CTP_IVL_US = 32;
  localparam int CTP_IVL_CYC = CTP_IVL_US * CTP_CLK_MHZ;
  localparam int CTP_VID_WIN_MS = 100;
  localparam int CTP_VID_WIN_CYC = CTP_VID_WIN_MS * 1000 * CTP_CLK_MHZ;
  typedef enum logic [1:0] {CTP_CPU_STOP_REQUEST_N_IDLE, CTP_CPU_STOP_REQUEST_N_REQ, CTP_CPU_STOP_REQUEST_N_HELD} ctp_cpu_stop_request_n_t;
endpackage
`default_nettype wire

/* File: hw/ctp_throttle_cfg.sv */
`default_nettype none
// Overview of operation
// - Config bit 4 high disables power savings, low keeps it active.
// - Config bit 3 selects whether the ISA clock stops in power savings.
// - Config bit 2 enables low-voltage suspend allowing processor power-down.
// - Policy bit 0: SYSTEM_MGMT_INTERRUPT loads interrupt speedup timer, throttling pauses meanwhile.
// - Policy bit 1: SYSTEM_MGMT_INTERRUPT halts throttling until the re-arm register is read.
// - Policy bit has no effect while throttle enable is zero.
// - Enable bit 1 alternates stop request for OFF and ON counts.
// - Video trigger starts 100 ms window; expiry while active counts and restarts.
// - With policy 1, reading the re-arm register re-enables halted throttling.
// - Re-arm read data meaningless; read while disabled has no effect.
// - Writes to ports 3F2h and 3F7h captured in read-only shadows.
// - Writes to ports 1F2h and 1F7h captured in read-only shadows.
// - Shadows follow snooped writes, reset undefined, not writable directly.
// - Suspend command register at index AEh gives software suspend entry.
// - Software SYSTEM_MGMT_INTERRUPT register at index D0h enters SYSTEM_MGMT_INTERRUPT by a write.
// - Suspend command write starts stop handshake if clock-stop bit and SYSTEM_MGMT_INTERRUPT status zero.
// - Any write to software SYSTEM_MGMT_INTERRUPT register raises an SYSTEM_MGMT_INTERRUPT, data ignored.
module ctp_throttle_cfg
  import ctp_pkg::*;
#(
  parameter int VID_WIN_CYC_P = CTP_VID_WIN_CYC,
  parameter int IVL_CYC_P = CTP_IVL_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic mem_rd,
  input wire logic [7:0] mem_addr,
  output logic [15:0] mem_rdata,
  input wire logic io_wr,
  input wire logic [15:0] io_addr,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] off_count,
  input wire logic [7:0] on_count,
  input wire logic smi_event,
  input wire logic irq_speedup_active,
  input wire logic video_speedup_trigger,
  input wire logic video_speedup_active,
  input wire logic clock_stop_ctrl,
  input wire logic smi_status_any,
  input wire logic wake_event,
  input wire logic cpu_stop_ack_n,
  output logic cpu_stop_request_n,
  output logic system_mgmt_interrupt,
  output logic irq_speedup_load,
  output logic power_savings_en,
  output logic isa_clk_stop_include,
  output logic low_voltage_suspend_en
);
  ctp_ctl_if u_ctl ();

  logic [7:0] cfg_q;
  logic [15:0] vovf_q;
  logic [7:0] sh_3f2_q;
  logic [7:0] sh_3f7_q;
  logic [7:0] sh_1f2_q;
  logic [7:0] sh_1f7_q;
  logic [7:0] cfg_rdata_q;
  logic [15:0] mem_rdata_q;
  logic sw_smi_q;
  logic smi_halt_q;
  logic stop_req_n_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic ack_s3_q;
  logic ack_q;
  ctp_cpu_stop_request_n_t cpu_stop_request_n_q;
  logic thr_en;
  logic smi_pol;
  logic smi_any;
  logic halt_set;
  logic rearm_rd;
  logic rearm_clr;
  logic cpu_stop_request_n_cmd_ok;
  logic wr_cfg;

  assign thr_en = cfg_q[CTP_THR_EN_BIT];
  assign smi_pol = cfg_q[CTP_SMI_POL_BIT];
  assign wr_cfg = cfg_wr && (cfg_addr == CTP_IDX_THR_CFG);
  assign smi_any = smi_event || sw_smi_q;
  assign halt_set = thr_en && smi_pol && smi_any;
  assign rearm_rd = mem_rd && (mem_addr == CTP_OFS_REARM);
  assign rearm_clr = rearm_rd && thr_en && smi_pol;
  assign cpu_stop_request_n_cmd_ok = cfg_wr && (cfg_addr == CTP_IDX_CPU_STOP_REQUEST_N_CMD) && !clock_stop_ctrl &&
                       !smi_status_any;

  // Reserved upper bits are not stored and read back as zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_q <= CTP_THR_CFG_RST;
    end else if (wr_cfg) begin
      cfg_q <= cfg_wdata & CTP_THR_CFG_WMASK;
    end
  end

  assign power_savings_en = !cfg_q[CTP_PWR_DIS_BIT];
  assign isa_clk_stop_include = cfg_q[CTP_ISA_CLK_BIT];
  assign low_voltage_suspend_en = cfg_q[CTP_LV_CPU_STOP_REQUEST_N_BIT];

  // Policy 0 hands the SYSTEM_MGMT_INTERRUPT to the external interrupt speedup timer
  assign irq_speedup_load = thr_en && !smi_pol && smi_any;

  // Set wins over a re-arm read in the same cycle
  always_ff @(posedge mclk) begin
    if (srst || !thr_en) begin
      smi_halt_q <= 1'b0;
    end else if (halt_set) begin
      smi_halt_q <= 1'b1;
    end else if (rearm_clr) begin
      smi_halt_q <= 1'b0;
    end
  end

  assign u_ctl.thr_run = thr_en && !smi_halt_q && !irq_speedup_active &&
                         !video_speedup_active;
  assign u_ctl.off_count = off_count;
  assign u_ctl.on_count = on_count;
  assign u_ctl.vid_trig = video_speedup_trigger;
  assign u_ctl.vid_active = video_speedup_active;

  ctp_modulator #(
    .IVL_CYC_P(IVL_CYC_P)
  ) u_mod (
    .mclk(mclk),
    .srst(srst),
    .ctl(u_ctl.mod_mp)
  );

  ctp_video_watch #(
    .WIN_CYC_P(VID_WIN_CYC_P)
  ) u_vid (
    .mclk(mclk),
    .srst(srst),
    .ctl(u_ctl.vid_mp)
  );

  // Hardware increment beats a same-cycle software write so no overflow is lost
  always_ff @(posedge mclk) begin
    if (srst) begin
      vovf_q <= CTP_VOVF_RST;
    end else if (u_ctl.ovf_inc) begin
      vovf_q <= vovf_q + 16'h0001;
    end else if (cfg_wr && cfg_addr == CTP_IDX_VOVF_LO) begin
      vovf_q[7:0] <= cfg_wdata;
    end else if (cfg_wr && cfg_addr == CTP_IDX_VOVF_HI) begin
      vovf_q[15:8] <= cfg_wdata;
    end
  end

  // Shadows carry no reset: their content is only meaningful after a snooped write
  always_ff @(posedge mclk) begin
    if (io_wr) begin
      if (io_addr == CTP_PORT_3F2) begin
        sh_3f2_q <= io_wdata;
      end
      if (io_addr == CTP_PORT_3F7) begin
        sh_3f7_q <= io_wdata;
      end
      if (io_addr == CTP_PORT_1F2) begin
        sh_1f2_q <= io_wdata;
      end
      if (io_addr == CTP_PORT_1F7) begin
        sh_1f7_q <= io_wdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sw_smi_q <= 1'b0;
    end else begin
      sw_smi_q <= cfg_wr && (cfg_addr == CTP_IDX_SW_SMI);
    end
  end

  assign system_mgmt_interrupt = sw_smi_q;

  // Write-only indices and unmapped indices read as zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_rdata_q <= 8'h00;
    end else if (cfg_rd) begin
      case (cfg_addr)
        CTP_IDX_THR_CFG: cfg_rdata_q <= cfg_q;
        CTP_IDX_VOVF_LO: cfg_rdata_q <= vovf_q[7:0];
        CTP_IDX_VOVF_HI: cfg_rdata_q <= vovf_q[15:8];
        CTP_IDX_SH_3F2: cfg_rdata_q <= sh_3f2_q;
        CTP_IDX_SH_3F7: cfg_rdata_q <= sh_3f7_q;
        CTP_IDX_SH_1F2: cfg_rdata_q <= sh_1f2_q;
        CTP_IDX_SH_1F7: cfg_rdata_q <= sh_1f7_q;
        default: cfg_rdata_q <= 8'h00;
      endcase
    end
  end

  assign cfg_rdata = cfg_rdata_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      mem_rdata_q <= 16'h0000;
    end else if (mem_rd) begin
      mem_rdata_q <= CTP_REARM_RDATA;
    end
  end

  assign mem_rdata = mem_rdata_q;

  // Acknowledge pin: three stages, change accepted when last two agree
  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_s1_q <= 1'b1;
      ack_s2_q <= 1'b1;
      ack_s3_q <= 1'b1;
    end else begin
      ack_s1_q <= cpu_stop_ack_n;
      ack_s2_q <= ack_s1_q;
      ack_s3_q <= ack_s2_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else if (ack_s2_q == ack_s3_q) begin
      ack_q <= !ack_s3_q;
    end
  end

  // Held until the processor acknowledges, then until a wake event or a SYSTEM_MGMT_INTERRUPT
  always_ff @(posedge mclk) begin
    if (srst) begin
      cpu_stop_request_n_q <= CTP_CPU_STOP_REQUEST_N_IDLE;
    end else begin
      case (cpu_stop_request_n_q)
        CTP_CPU_STOP_REQUEST_N_IDLE: if (cpu_stop_request_n_cmd_ok) begin
          cpu_stop_request_n_q <= CTP_CPU_STOP_REQUEST_N_REQ;
        end
        CTP_CPU_STOP_REQUEST_N_REQ: if (ack_q) begin
          cpu_stop_request_n_q <= CTP_CPU_STOP_REQUEST_N_HELD;
        end
        CTP_CPU_STOP_REQUEST_N_HELD: if (wake_event || smi_any) begin
          cpu_stop_request_n_q <= CTP_CPU_STOP_REQUEST_N_IDLE;
        end
        default: cpu_stop_request_n_q <= CTP_CPU_STOP_REQUEST_N_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      stop_req_n_q <= 1'b1;
    end else begin
      stop_req_n_q <= !(u_ctl.mod_stop || cpu_stop_request_n_q != CTP_CPU_STOP_REQUEST_N_IDLE);
    end
  end

  assign cpu_stop_request_n = stop_req_n_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  property p_pwr_gate;
    wr_cfg |=> power_savings_en == !$past(cfg_wdata[CTP_PWR_DIS_BIT]);
  endproperty
  a_pwr_gate: assert property (p_pwr_gate) else $error("power savings gate wrong");
  property p_isa_clk;
    wr_cfg |=> isa_clk_stop_include == $past(cfg_wdata[CTP_ISA_CLK_BIT]);
  endproperty
  a_isa_clk: assert property (p_isa_clk) else $error("ISA clock select wrong");
  property p_lv_cpu_stop_request_n;
    wr_cfg |=> low_voltage_suspend_en == $past(cfg_wdata[CTP_LV_CPU_STOP_REQUEST_N_BIT]);
  endproperty
  a_lv_cpu_stop_request_n: assert property (p_lv_cpu_stop_request_n) else $error("low-voltage suspend wrong");
  property p_pol0_load;
    smi_event && thr_en && !smi_pol |-> irq_speedup_load ##1 !smi_halt_q;
  endproperty
  a_pol0_load: assert property (p_pol0_load) else $error("policy 0 SYSTEM_MGMT_INTERRUPT misrouted");
  sequence s_halted;
    smi_halt_q && !u_ctl.thr_run ##1 !u_ctl.mod_stop;
  endsequence
  property p_pol1_halt;
    halt_set |=> s_halted;
  endproperty
  a_pol1_halt: assert property (p_pol1_halt) else $error("policy 1 SYSTEM_MGMT_INTERRUPT did not halt");
  property p_halt_hold;
    smi_halt_q && !rearm_clr && thr_en |=> smi_halt_q;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt dropped without re-arm");
  property p_dis_nohalt;
    !thr_en |-> !irq_speedup_load ##1 !smi_halt_q;
  endproperty
  a_dis_nohalt: assert property (p_dis_nohalt) else $error("policy acted while disabled");
  property p_rearm;
    rearm_clr && !halt_set |=> !smi_halt_q;
  endproperty
  a_rearm: assert property (p_rearm) else $error("re-arm read did not clear halt");
  property p_rearm_data;
    mem_rd |=> mem_rdata == CTP_REARM_RDATA;
  endproperty
  a_rearm_data: assert property (p_rearm_data) else $error("re-arm data not constant");
  property p_sh_3f2;
    io_wr && io_addr == CTP_PORT_3F2 |=> sh_3f2_q == $past(io_wdata);
  endproperty
  a_sh_3f2: assert property (p_sh_3f2) else $error("3F2 shadow not captured");
  property p_sh_1f7;
    io_wr && io_addr == CTP_PORT_1F7 |=> sh_1f7_q == $past(io_wdata);
  endproperty
  a_sh_1f7: assert property (p_sh_1f7) else $error("1F7 shadow not captured");
  property p_sh_stable;
    !io_wr |=> $stable(sh_1f2_q) && $stable(sh_3f7_q);
  endproperty
  a_sh_stable: assert property (p_sh_stable) else $error("shadow changed without snoop");
  property p_cpu_stop_request_n_start;
    cpu_stop_request_n_cmd_ok && cpu_stop_request_n_q == CTP_CPU_STOP_REQUEST_N_IDLE |=> ##1 !cpu_stop_request_n;
  endproperty
  a_cpu_stop_request_n_start: assert property (p_cpu_stop_request_n_start) else $error("suspend handshake not started");
  property p_cpu_stop_request_n_block;
    cfg_wr && cfg_addr == CTP_IDX_CPU_STOP_REQUEST_N_CMD && clock_stop_ctrl && cpu_stop_request_n_q == CTP_CPU_STOP_REQUEST_N_IDLE
      |=> cpu_stop_request_n_q == CTP_CPU_STOP_REQUEST_N_IDLE;
  endproperty
  a_cpu_stop_request_n_block: assert property (p_cpu_stop_request_n_block) else $error("suspend ignored clock-stop");
  property p_sw_smi;
    cfg_wr && cfg_addr == CTP_IDX_SW_SMI |=> system_mgmt_interrupt ##1 !system_mgmt_interrupt
      or system_mgmt_interrupt ##1 system_mgmt_interrupt;
  endproperty
  a_sw_smi: assert property (p_sw_smi) else $error("software SYSTEM_MGMT_INTERRUPT not raised");
endmodule // ctp_throttle_cfg
`default_nettype wire

/* File: hw/ctp_video_watch.sv */
`default_nettype none
module ctp_video_watch
  import ctp_pkg::*;
#(
  parameter int WIN_CYC_P = CTP_VID_WIN_CYC
) (
  input wire logic mclk,
  input wire logic srst,
  ctp_ctl_if.vid_mp ctl
);
  localparam int WW = $clog2(WIN_CYC_P);
  if (WIN_CYC_P < 2) begin : g_chk
    $error("ctp_video_watch: window must be at least two cycles");
  end
  logic [WW-1:0] win_q;
  logic expire;
  logic ovf_inc_q;

  assign expire = ctl.vid_active && !ctl.vid_trig && (win_q == WW'(WIN_CYC_P - 1));

  // Every trigger restarts the window; a lapsed speedup stops it
  always_ff @(posedge mclk) begin
    if (srst || ctl.vid_trig || !ctl.vid_active || expire) begin
      win_q <= '0;
    end else begin
      win_q <= win_q + WW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ovf_inc_q <= 1'b0;
    end else begin
      ovf_inc_q <= expire;
    end
  end

  assign ctl.ovf_inc = ovf_inc_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  property p_vid_inc;
    expire |=> ctl.ovf_inc ##1 !ctl.ovf_inc;
  endproperty
  a_vid_inc: assert property (p_vid_inc) else $error("overflow not counted once");
  property p_vid_quiet;
    !ctl.vid_active |=> !ctl.ovf_inc;
  endproperty
  a_vid_quiet: assert property (p_vid_quiet) else $error("overflow without speedup");
endmodule // ctp_video_watch
`default_nettype wire
